// ---- verilog/sxt_pkg.sv ----
// Purpose: shared constants for the swap/xor/direction-load execution datapath
// Assumes: 8-bit data, 7-bit file address, operand field 5..7 selects a direction register
// Notes: opcode selection is supplied already decoded as a small enum
`default_nettype none
package sxt_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned NIB_HI = 4;
  localparam logic DEST_W = 1'h0;
  localparam logic DEST_F = 1'h1;
  localparam logic [ADDR_W-1:0] DIR_A_SEL = 7'h05;
  localparam logic [ADDR_W-1:0] DIR_B_SEL = 7'h06;
  localparam logic [ADDR_W-1:0] DIR_C_SEL = 7'h07;
  localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
  localparam logic ZERO_RESET = 1'h0;

  typedef enum logic [2:0] {
    SXT_OP_NONE = 3'h0,
    SXT_OP_SWAP = 3'h1,
    SXT_OP_XORL = 3'h2,
    SXT_OP_XORF = 3'h3,
    SXT_OP_DIR = 3'h4
  } sxt_op_t;
endpackage : sxt_pkg
`default_nettype wire

// ---- verilog/sxt_dir_reg.sv ----
// Purpose: one port direction register loaded from the working register
// Assumes: load is a one-cycle strobe
// Notes: resets to all inputs
`timescale 1ns/1ps
`default_nettype none
module sxt_dir_reg
  import sxt_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] dir_o
);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dir_o <= DIR_RESET;
    end else if (load_i) begin
      dir_o <= data_i;
    end
  end
endmodule // sxt_dir_reg
`default_nettype wire

// ---- verilog/sxt_exec.sv ----
// Purpose: execution datapath for nibble swap, xor literal, xor file and direction load
// Assumes: one instruction per clock, file operand read combinationally from outside
// Notes: file write-back is a registered one-cycle strobe with address and data
//
// Contract
// - nibble swap puts the operand low nibble in the upper half and high nibble in the lower.
// - for swap and xor with file, destination bit 0 writes the result to the working register, 1 back to the file register.
// - xor with literal xors the working register with the immediate into it, touching only zero.
// - xor with file xors the working register with the file operand, routed by destination.
// - direction load copies the working register into port A, B or C direction for 5, 6 or 7.
`timescale 1ns/1ps
`default_nettype none
module sxt_exec
  import sxt_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic exec_i,
  input wire sxt_op_t op_i,
  input wire logic dest_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] literal_i,
  input wire logic [DATA_W-1:0] file_data_i,
  output logic [DATA_W-1:0] wreg_o,
  output logic zero_o,
  output logic file_we_o,
  output logic [ADDR_W-1:0] file_addr_o,
  output logic [DATA_W-1:0] file_wdata_o,
  output logic [DATA_W-1:0] port_a_direction_o,
  output logic [DATA_W-1:0] port_b_direction_o,
  output logic [DATA_W-1:0] port_c_direction_o
);
  // ----------------------------------------------------------------
  // decode and result selection
  // ----------------------------------------------------------------
  wire logic is_swap = exec_i && (op_i == SXT_OP_SWAP);
  wire logic is_xorl = exec_i && (op_i == SXT_OP_XORL);
  wire logic is_xorf = exec_i && (op_i == SXT_OP_XORF);
  wire logic is_dir = exec_i && (op_i == SXT_OP_DIR);
  wire logic [DATA_W-1:0] swap_res =
    {file_data_i[NIB_HI-1:0], file_data_i[DATA_W-1:NIB_HI]};
  wire logic [DATA_W-1:0] xorl_res = wreg_o ^ literal_i;
  wire logic [DATA_W-1:0] xorf_res = wreg_o ^ file_data_i;
  wire logic [DATA_W-1:0] result = is_swap ? swap_res : (is_xorl ? xorl_res : xorf_res);
  wire logic file_form = is_swap || is_xorf;
  // literal xor always targets the working register regardless of dest
  wire logic to_w = is_xorl || (file_form && dest_i == DEST_W);
  wire logic to_f = file_form && dest_i == DEST_F;
  wire logic zero_upd = is_xorl || is_xorf;
  wire logic next_zero = (result == '0);
  // out-of-range operand loads nothing, so a bad decode cannot disturb the pins
  wire logic ld_a = is_dir && addr_i == DIR_A_SEL;
  wire logic ld_b = is_dir && addr_i == DIR_B_SEL;
  wire logic ld_c = is_dir && addr_i == DIR_C_SEL;

  // ----------------------------------------------------------------
  // working register, zero flag, file write-back
  // ----------------------------------------------------------------
  // write-back is registered so the file side sees a clean one-cycle strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wreg_o <= WREG_RESET;
      zero_o <= ZERO_RESET;
      file_we_o <= 1'h0;
      file_addr_o <= '0;
      file_wdata_o <= '0;
    end else begin
      if (to_w) begin
        wreg_o <= result;
      end
      if (zero_upd) begin
        zero_o <= next_zero;
      end
      file_we_o <= to_f;
      if (to_f) begin
        file_addr_o <= addr_i;
        file_wdata_o <= result;
      end
    end
  end

  // ----------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------
  sxt_dir_reg u_dir_a (
    .clk_i(clk_i), .reset_i(reset_i), .load_i(ld_a), .data_i(wreg_o),
    .dir_o(port_a_direction_o)
  );
  sxt_dir_reg u_dir_b (
    .clk_i(clk_i), .reset_i(reset_i), .load_i(ld_b), .data_i(wreg_o),
    .dir_o(port_b_direction_o)
  );
  sxt_dir_reg u_dir_c (
    .clk_i(clk_i), .reset_i(reset_i), .load_i(ld_c), .data_i(wreg_o),
    .dir_o(port_c_direction_o)
  );

  // ----------------------------------------------------------------
  // checks: nibble swap and destination routing
  // ----------------------------------------------------------------
  // expected values are rebuilt from the sampled inputs rather than from the
  // result mux, so a wrong leg in the mux cannot hide behind its own output

  sequence s_swap_file;
    is_swap && dest_i == DEST_F;
  endsequence

  sequence s_swap_w;
    is_swap && dest_i == DEST_W;
  endsequence

  // a write-back followed by a cycle with nothing for the file
  sequence s_write_then_quiet;
    to_f ##1 !to_f;
  endsequence

  property p_swap_nibbles;
    @(posedge clk_i) disable iff (reset_i)
      s_swap_file |=> file_we_o && file_wdata_o[7:4] == $past(file_data_i[3:0])
        && file_wdata_o[3:0] == $past(file_data_i[7:4]);
  endproperty
  a_swap_nibbles: assert property (p_swap_nibbles) else $error("swap result wrong");

  property p_swap_w;
    @(posedge clk_i) disable iff (reset_i)
      s_swap_w |=> wreg_o[7:4] == $past(file_data_i[3:0])
        && wreg_o[3:0] == $past(file_data_i[7:4]);
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap into working reg wrong");

  property p_dest_w;
    @(posedge clk_i) disable iff (reset_i)
      (file_form && dest_i == DEST_W) |=> !file_we_o
        && wreg_o == ($past(is_swap) ? {$past(file_data_i[3:0]), $past(file_data_i[7:4])}
        : ($past(wreg_o) ^ $past(file_data_i)));
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("dest 0 not to working reg");

  property p_dest_f;
    @(posedge clk_i) disable iff (reset_i)
      (file_form && dest_i == DEST_F) |=> file_we_o && $stable(wreg_o)
        && file_addr_o == $past(addr_i);
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("dest 1 not to file");

  property p_wreg_hold;
    @(posedge clk_i) disable iff (reset_i)
      !to_w |=> $stable(wreg_o);
  endproperty
  a_wreg_hold: assert property (p_wreg_hold) else $error("working reg changed");

  property p_write_quiet;
    @(posedge clk_i) disable iff (reset_i)
      s_write_then_quiet |=> !file_we_o && $stable(file_addr_o) && $stable(file_wdata_o);
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("file write not one cycle");

  // ----------------------------------------------------------------
  // checks: xor and zero flag
  // ----------------------------------------------------------------
  sequence s_xor_any;
    is_xorl || is_xorf;
  endsequence

  property p_xorl;
    @(posedge clk_i) disable iff (reset_i)
      is_xorl |=> wreg_o == ($past(wreg_o) ^ $past(literal_i)) && !file_we_o;
  endproperty
  a_xorl: assert property (p_xorl) else $error("xor literal wrong");

  property p_xorf;
    @(posedge clk_i) disable iff (reset_i)
      (is_xorf && dest_i == DEST_F) |=> file_wdata_o == ($past(wreg_o) ^ $past(file_data_i));
  endproperty
  a_xorf: assert property (p_xorf) else $error("xor file wrong");

  property p_zero_hold;
    @(posedge clk_i) disable iff (reset_i)
      !zero_upd |=> $stable(zero_o);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("flag changed");

  property p_zero_val;
    @(posedge clk_i) disable iff (reset_i)
      is_xorl |=> zero_o == (wreg_o == 8'h00);
  endproperty
  a_zero_val: assert property (p_zero_val) else $error("zero flag wrong");

  // the file form must flag a zero result even when it goes back to the file
  property p_zero_any;
    @(posedge clk_i) disable iff (reset_i)
      s_xor_any |=> zero_o == (($past(wreg_o)
        ^ ($past(is_xorl) ? $past(literal_i) : $past(file_data_i))) == 8'h00);
  endproperty
  a_zero_any: assert property (p_zero_any) else $error("zero flag from xor wrong");

  // ----------------------------------------------------------------
  // checks: direction registers
  // ----------------------------------------------------------------
  sequence s_dir_miss;
    is_dir && (addr_i < DIR_A_SEL || addr_i > DIR_C_SEL);
  endsequence

  property p_dir_b;
    @(posedge clk_i) disable iff (reset_i)
      ld_b |=> port_b_direction_o == $past(wreg_o) && $stable(port_a_direction_o)
        && $stable(port_c_direction_o);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("direction load B wrong");

  property p_dir_ac;
    @(posedge clk_i) disable iff (reset_i)
      (ld_a || ld_c) |=> $stable(port_b_direction_o) && ($past(ld_a)
        ? (port_a_direction_o == $past(wreg_o) && $stable(port_c_direction_o))
        : (port_c_direction_o == $past(wreg_o) && $stable(port_a_direction_o)));
  endproperty
  a_dir_ac: assert property (p_dir_ac) else $error("direction load A/C wrong");

  property p_dir_miss;
    @(posedge clk_i) disable iff (reset_i)
      s_dir_miss |=> $stable(port_a_direction_o) && $stable(port_b_direction_o)
        && $stable(port_c_direction_o);
  endproperty
  a_dir_miss: assert property (p_dir_miss) else $error("bad operand loaded a direction");

  property p_dir_hold;
    @(posedge clk_i) disable iff (reset_i)
      !is_dir |=> $stable(port_a_direction_o) && $stable(port_b_direction_o)
        && $stable(port_c_direction_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed without load");
endmodule // sxt_exec
`default_nettype wire

// ---- verification/sxt_exec_tb.sv ----
// Purpose: self-checking bench for the swap/xor/direction-load datapath
// Assumes: inputs change on the falling edge, one instruction per exec strobe
// Notes: expected values are worked out by hand from the instruction semantics
`timescale 1ns/1ps
`default_nettype none
module sxt_exec_tb;
  import sxt_pkg::*;
  logic clk_i, reset_i, exec_i, dest_i, zero_o, file_we_o;
  sxt_op_t op_i;
  logic [ADDR_W-1:0] addr_i, file_addr_o;
  logic [DATA_W-1:0] literal_i, file_data_i, wreg_o, file_wdata_o, dir_a, dir_b, dir_c;
  int error_cnt, samples_checked, cycles;

  sxt_exec sxt_exec_i (.clk_i(clk_i), .reset_i(reset_i), .exec_i(exec_i), .op_i(op_i),
    .dest_i(dest_i), .addr_i(addr_i), .literal_i(literal_i), .file_data_i(file_data_i),
    .wreg_o(wreg_o), .zero_o(zero_o), .file_we_o(file_we_o), .file_addr_o(file_addr_o),
    .file_wdata_o(file_wdata_o), .port_a_direction_o(dir_a), .port_b_direction_o(dir_b),
    .port_c_direction_o(dir_c));

  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // file operand is scrambled after the strobe so a stale read cannot pass
  task automatic run(input sxt_op_t op, input logic d, input logic [6:0] a,
                     input logic [7:0] lit, input logic [7:0] fd);
    @(negedge clk_i);
    exec_i = 1'h1;
    op_i = op;
    dest_i = d;
    addr_i = a;
    literal_i = lit;
    file_data_i = fd;
    @(negedge clk_i);
    exec_i = 1'h0;
    file_data_i = ~fd;
  endtask

  task automatic state(input logic [7:0] w, input logic z, input logic [7:0] a,
                       input logic [7:0] b, input logic [7:0] c);
    chk("wreg", wreg_o, w);
    chk("zero", {7'h00, zero_o}, {7'h00, z});
    chk("dir_a", dir_a, a);
    chk("dir_b", dir_b, b);
    chk("dir_c", dir_c, c);
  endtask

  task automatic fw(input logic we, input logic [6:0] a, input logic [7:0] d);
    chk("file_we", {7'h00, file_we_o}, {7'h00, we});
    chk("file_addr", {1'h0, file_addr_o}, {1'h0, a});
    chk("file_wdata", file_wdata_o, d);
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 500) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    {reset_i, exec_i, dest_i} = 3'h4;
    op_i = SXT_OP_NONE;
    addr_i = 7'h00;
    literal_i = 8'h00;
    file_data_i = 8'h00;
    repeat (4) @(negedge clk_i);
    reset_i = 1'h0;
    state(8'h00, 1'h0, 8'hFF, 8'hFF, 8'hFF);
    fw(1'h0, 7'h00, 8'h00);
    run(SXT_OP_XORL, DEST_F, 7'h00, 8'hA5, 8'h00);
    state(8'hA5, 1'h0, 8'hFF, 8'hFF, 8'hFF);
    fw(1'h0, 7'h00, 8'h00);
    run(SXT_OP_XORL, DEST_W, 7'h00, 8'hA5, 8'h00);
    state(8'h00, 1'h1, 8'hFF, 8'hFF, 8'hFF);
    run(SXT_OP_SWAP, DEST_W, 7'h10, 8'h00, 8'hA5);
    state(8'h5A, 1'h1, 8'hFF, 8'hFF, 8'hFF);
    fw(1'h0, 7'h00, 8'h00);
    run(SXT_OP_SWAP, DEST_F, 7'h10, 8'h00, 8'h3C);
    state(8'h5A, 1'h1, 8'hFF, 8'hFF, 8'hFF);
    fw(1'h1, 7'h10, 8'hC3);
    run(SXT_OP_XORF, DEST_F, 7'h20, 8'h00, 8'h0F);
    state(8'h5A, 1'h0, 8'hFF, 8'hFF, 8'hFF);
    fw(1'h1, 7'h20, 8'h55);
    run(SXT_OP_XORF, DEST_W, 7'h21, 8'h00, 8'h5A);
    state(8'h00, 1'h1, 8'hFF, 8'hFF, 8'hFF);
    fw(1'h0, 7'h20, 8'h55);
    run(SXT_OP_DIR, DEST_W, 7'h05, 8'h00, 8'h00);
    state(8'h00, 1'h1, 8'h00, 8'hFF, 8'hFF);
    run(SXT_OP_XORL, DEST_W, 7'h00, 8'hAA, 8'h00);
    run(SXT_OP_DIR, DEST_W, 7'h06, 8'h00, 8'h00);
    state(8'hAA, 1'h0, 8'h00, 8'hAA, 8'hFF);
    run(SXT_OP_XORL, DEST_W, 7'h00, 8'h0F, 8'h00);
    run(SXT_OP_DIR, DEST_W, 7'h07, 8'h00, 8'h00);
    state(8'hA5, 1'h0, 8'h00, 8'hAA, 8'hA5);
    run(SXT_OP_DIR, DEST_W, 7'h04, 8'h00, 8'h00);
    state(8'hA5, 1'h0, 8'h00, 8'hAA, 8'hA5);
    run(SXT_OP_XORF, DEST_F, 7'h22, 8'h00, 8'hA5);
    state(8'hA5, 1'h1, 8'h00, 8'hAA, 8'hA5);
    fw(1'h1, 7'h22, 8'h00);
    run(sxt_op_t'(3'h7), DEST_F, 7'h05, 8'hFF, 8'hFF);
    state(8'hA5, 1'h1, 8'h00, 8'hAA, 8'hA5);
    fw(1'h0, 7'h22, 8'h00);
    print_verdict();
  end
endmodule // sxt_exec_tb
`default_nettype wire
